/* nas_pkg.sv */
package nas_pkg;
	localparam int CLK_KHZ    = 40000;
	localparam int STARTUP_MS = 500;
	localparam int STARTUP_CYC = STARTUP_MS * CLK_KHZ;
	localparam int STARTUP_W  = 25;
	localparam int ADDR_W     = 7;
	localparam int SW_W       = 4;
	localparam int N_IN       = 6;
	localparam int FUNC_W     = 3;
	localparam int N_OUT      = 3;
	localparam int STEP_IN    = 0;
	localparam logic [3:0] SW_NV_HI = 4'h8;
	localparam logic [3:0] SW_SUB_LO = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
	localparam logic [3:0] SW_RST = 4'h0;

	typedef enum logic [2:0] {
		RATE_1M,
		RATE_500K,
		RATE_250K,
		RATE_125K,
		RATE_50K,
		RATE_20K
	} nas_rate_e;

	localparam logic [1:0] CODE_FAULT = 2'h0;
	localparam logic [1:0] CODE_IDLE  = 2'h1;
	localparam logic [1:0] CODE_BUSY  = 2'h2;
	localparam logic [1:0] CODE_REF   = 2'h3;

	localparam logic [2:0] FN_NONE    = 3'h0;
	localparam logic [2:0] FN_LIM_POS = 3'h1;
	localparam logic [2:0] FN_LIM_NEG = 3'h2;
	localparam logic [2:0] FN_ENABLE  = 3'h3;
	localparam logic [2:0] FN_REF     = 3'h4;

	function automatic logic sw_uses_nv(input logic [3:0] sw);
		return sw[2:0] == 3'h0;
	endfunction

	function automatic logic [ADDR_W-1:0] sw_to_addr(input logic [3:0] sw,
		input logic [ADDR_W-1:0] nv);
		logic [3:0] a;
		a = (sw >= SW_SUB_LO) ? sw - SW_NV_HI : sw;
		return sw_uses_nv(sw) ? nv : {3'h0, a};
	endfunction

	function automatic nas_rate_e rate_pick(input logic [3:0] sw, input logic canopen,
		input logic [2:0] nv);
		nas_rate_e r;
		r = (nv > 3'(RATE_20K)) ? RATE_1M : nas_rate_e'(nv);
		return (sw == 4'h0 && canopen) ? RATE_1M : r;
	endfunction
endpackage

/* nas_cfg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface nas_cfg_if;
	logic                          take;
	logic [nas_pkg::SW_W-1:0]      sw_raw;
	logic [nas_pkg::ADDR_W-1:0]    nv_addr;
	logic [2:0]                    nv_rate;
	logic                          canopen;
	logic [nas_pkg::SW_W-1:0]      sw_held;
	logic [nas_pkg::ADDR_W-1:0]    node_address;
	nas_pkg::nas_rate_e            bit_rate;
	logic                          valid;

	modport top (
		output take,
		output sw_raw,
		output nv_addr,
		output nv_rate,
		output canopen,
		input  sw_held,
		input  node_address,
		input  bit_rate,
		input  valid
	);
	modport latch (
		input  take,
		input  sw_raw,
		input  nv_addr,
		input  nv_rate,
		input  canopen,
		output sw_held,
		output node_address,
		output bit_rate,
		output valid
	);
endinterface
`default_nettype wire

/* nas_cfg_latch.sv */
`timescale 1ns/10ps
`default_nettype none
module nas_cfg_latch (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	nas_cfg_if.latch  cfg
);
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			cfg.sw_held      <= nas_pkg::SW_RST;
			cfg.node_address <= nas_pkg::ADDR_RST;
			cfg.bit_rate     <= nas_pkg::RATE_1M;
			cfg.valid        <= 1'b0;
		end
		else if (cfg.take && !cfg.valid)
		begin
			cfg.sw_held      <= cfg.sw_raw;
			cfg.node_address <= nas_pkg::sw_to_addr(cfg.sw_raw, cfg.nv_addr);
			cfg.bit_rate     <= nas_pkg::rate_pick(cfg.sw_raw, cfg.canopen, cfg.nv_rate);
			cfg.valid        <= 1'b1;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	held_stable_a: assert property (cfg.valid |=> $stable(cfg.node_address) && $stable(cfg.bit_rate) && $stable(cfg.sw_held)) else $error("config changed after capture");
	addr_switch_a: assert property (!i_rst && cfg.take && !cfg.valid && !nas_pkg::sw_uses_nv(cfg.sw_raw) |=> cfg.node_address[2:0] == $past(cfg.sw_raw[2:0]) && cfg.node_address[6:3] == 4'h0) else $error("address not from switch");
	addr_nv_a: assert property (!i_rst && cfg.take && !cfg.valid && nas_pkg::sw_uses_nv(cfg.sw_raw) |=> cfg.node_address == $past(cfg.nv_addr)) else $error("address not from storage");
	rate_force_a: assert property (!i_rst && cfg.take && !cfg.valid && cfg.sw_raw == 4'h0 && cfg.canopen |=> cfg.bit_rate == nas_pkg::RATE_1M) else $error("rate not forced");
	rate_nv_a: assert property (!i_rst && cfg.take && !cfg.valid && cfg.sw_raw[3] && cfg.nv_rate <= 3'h5 |=> cfg.bit_rate == $past(cfg.nv_rate)) else $error("rate not from storage");
endmodule
`default_nettype wire

/* nas_top.sv */
`timescale 1ns/10ps
`default_nettype none
module nas_top #(
	parameter int STARTUP_CYC = nas_pkg::STARTUP_CYC
) (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_rst,
	input  wire logic [nas_pkg::SW_W-1:0]     i_rot_sw,
	input  wire logic [nas_pkg::ADDR_W-1:0]   i_nv_addr,
	input  wire logic [2:0]                   i_nv_rate,
	input  wire logic                         i_canopen,
	input  wire logic [nas_pkg::N_IN-1:0]     i_din,
	input  wire logic [nas_pkg::N_IN-1:0]     i_din_act_high,
	input  wire logic [nas_pkg::N_IN*nas_pkg::FUNC_W-1:0] i_din_func,
	input  wire logic                         i_clkdir_mode,
	input  wire logic                         i_rot_err,
	input  wire logic                         i_busy,
	input  wire logic                         i_ref_reached,
	input  wire logic                         i_overtemp,
	input  wire logic                         i_fault,
	input  wire logic [nas_pkg::N_OUT-1:0]    i_out_prog_en,
	input  wire logic [nas_pkg::N_OUT-1:0]    i_out_prog_val,
	output logic [nas_pkg::ADDR_W-1:0]        o_node_address,
	output nas_pkg::nas_rate_e                o_bit_rate,
	output logic [nas_pkg::SW_W-1:0]          o_sw_held,
	output logic                              o_cfg_valid,
	output logic [nas_pkg::N_IN-1:0]          o_din_active,
	output logic                              o_lim_pos,
	output logic                              o_lim_neg,
	output logic                              o_enable,
	output logic                              o_ref_in,
	output logic                              o_step_clk,
	output logic                              o_startup,
	output logic [nas_pkg::N_OUT-1:0]         o_stat_active,
	output logic [nas_pkg::N_OUT-1:0]         o_stat_o,
	output logic [nas_pkg::N_OUT-1:0]         o_stat_oe
);
	typedef enum logic [1:0] {
		ST_SAMPLE,
		ST_STARTUP,
		ST_RUN
	} nas_state_e;

	nas_state_e                    state_reg;
	logic [nas_pkg::STARTUP_W-1:0] start_cnt_reg;
	logic [nas_pkg::N_IN-1:0]      act_reg;
	logic [nas_pkg::N_OUT-1:0]     stat_reg;
	logic [nas_pkg::N_OUT-1:0]     stat_next;
	logic [nas_pkg::N_IN-1:0]      act_next;
	logic                          lim_pos_next;
	logic                          lim_neg_next;
	logic                          enable_next;
	logic                          ref_next;
	logic [1:0]                    code_next;

	localparam logic [nas_pkg::STARTUP_W-1:0] START_LAST =
		nas_pkg::STARTUP_W'(STARTUP_CYC - 1);

	nas_cfg_if cfg ();

	assign cfg.take    = (state_reg == ST_SAMPLE);
	assign cfg.sw_raw  = i_rot_sw;
	assign cfg.nv_addr = i_nv_addr;
	assign cfg.nv_rate = i_nv_rate;
	assign cfg.canopen = i_canopen;

	nas_cfg_latch u_latch (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.cfg       (cfg)
	);

	assign o_bit_rate     = cfg.bit_rate;
	assign o_node_address = cfg.node_address;
	assign o_sw_held      = cfg.sw_held;
	assign o_cfg_valid    = cfg.valid;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= ST_SAMPLE;
		end
		else
		begin
			case (state_reg)
				ST_SAMPLE:
				begin
					state_reg <= ST_STARTUP;
				end
				ST_STARTUP:
				begin
					if (start_cnt_reg == START_LAST)
					begin
						state_reg <= ST_RUN;
					end
				end
				default:
				begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			start_cnt_reg <= '0;
		end
		else if (state_reg == ST_STARTUP && start_cnt_reg != START_LAST)
		begin
			start_cnt_reg <= start_cnt_reg + 1'b1;
		end
	end

	assign o_startup = (state_reg != ST_RUN);

	// input conditioning and function routing
	always_comb
	begin
		logic [2:0] fn;
		fn           = nas_pkg::FN_NONE;
		act_next     = ~(i_din ^ i_din_act_high);
		lim_pos_next = 1'b0;
		lim_neg_next = 1'b0;
		enable_next  = 1'b0;
		ref_next     = 1'b0;
		for (int i = 0; i < nas_pkg::N_IN; i++)
		begin
			fn = i_din_func[i*nas_pkg::FUNC_W +: nas_pkg::FUNC_W];
			if (i_clkdir_mode && i == nas_pkg::STEP_IN)
			begin
				fn = nas_pkg::FN_NONE;
			end
			if (act_next[i])
			begin
				case (fn)
					nas_pkg::FN_LIM_POS: lim_pos_next = 1'b1;
					nas_pkg::FN_LIM_NEG: lim_neg_next = 1'b1;
					nas_pkg::FN_ENABLE:  enable_next = 1'b1;
					nas_pkg::FN_REF:     ref_next = 1'b1;
					default:             ;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			act_reg    <= '0;
			o_lim_pos  <= 1'b0;
			o_lim_neg  <= 1'b0;
			o_enable   <= 1'b0;
			o_ref_in   <= 1'b0;
			o_step_clk <= 1'b0;
		end
		else
		begin
			act_reg    <= act_next;
			o_lim_pos  <= lim_pos_next;
			o_lim_neg  <= lim_neg_next;
			o_enable   <= enable_next;
			o_ref_in   <= ref_next;
			o_step_clk <= i_clkdir_mode & act_next[nas_pkg::STEP_IN];
		end
	end

	assign o_din_active = act_reg;

	// status encoding
	always_comb
	begin
		if (i_rot_err || lim_pos_next || lim_neg_next)
		begin
			code_next = nas_pkg::CODE_FAULT;
		end
		else if (i_ref_reached)
		begin
			code_next = nas_pkg::CODE_REF;
		end
		else if (i_busy)
		begin
			code_next = nas_pkg::CODE_BUSY;
		end
		else
		begin
			code_next = nas_pkg::CODE_IDLE;
		end
		stat_next = {i_overtemp | i_fault | o_startup, code_next};
		if (i_canopen)
		begin
			stat_next = '0;
		end
		for (int k = 0; k < nas_pkg::N_OUT; k++)
		begin
			if (i_out_prog_en[k])
			begin
				stat_next[k] = i_out_prog_val[k];
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			stat_reg <= '0;
		end
		else
		begin
			stat_reg <= stat_next;
		end
	end

	assign o_stat_active = stat_reg;
	assign o_stat_o      = '0;
	assign o_stat_oe     = stat_reg;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sample_once_a: assert property (!i_rst && state_reg == ST_SAMPLE |=> o_cfg_valid && state_reg == ST_STARTUP) else $error("switch not sampled");
	no_resample_a: assert property (o_cfg_valid && $changed(i_rot_sw) |=> $stable(o_node_address)) else $error("address followed switch");
	code_fault_a: assert property (!i_canopen && i_out_prog_en[1:0] == 2'h0 && i_rot_err |=> o_stat_active[1:0] == 2'h0) else $error("fault code wrong");
	code_busy_a: assert property (!i_canopen && i_out_prog_en[1:0] == 2'h0 && !i_rot_err && !lim_pos_next && !lim_neg_next && !i_ref_reached && i_busy |=> o_stat_active[1:0] == 2'h2) else $error("busy code wrong");
	overtemp_out_a: assert property (!i_canopen && !i_out_prog_en[2] && i_overtemp |=> o_stat_active[2]) else $error("overtemp not shown");
	override_out_a: assert property (i_out_prog_en[0] |=> o_stat_active[0] == $past(i_out_prog_val[0])) else $error("override ignored");
	canopen_quiet_a: assert property (i_canopen && i_out_prog_en == 3'h0 |=> o_stat_active == 3'h0) else $error("state shown in CANopen");
	open_drain_a: assert property (o_stat_o == 3'h0 && o_stat_oe == o_stat_active) else $error("output not open drain");
	polarity_in_a: assert property (!i_rst |=> o_din_active == $past(~(i_din ^ i_din_act_high))) else $error("polarity wrong");
	step_fixed_a: assert property (i_clkdir_mode && i_din_func[2:0] == nas_pkg::FN_ENABLE && i_din_func[17:3] == 15'h0 |=> !o_enable) else $error("step input remapped");

	startup_c: cover property (state_reg == ST_STARTUP ##1 state_reg == ST_RUN);
	ref_code_c: cover property (o_stat_active[1:0] == nas_pkg::CODE_REF);
	nv_addr_c: cover property (o_cfg_valid && o_sw_held == 4'h8);
	step_clk_c: cover property (o_step_clk);
endmodule
`default_nettype wire

/* nas_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nas_master_model #(
	parameter logic [2:0] MASTER_RATE = 3'h2
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic               i_cfg_valid,
	input  wire nas_pkg::nas_rate_e i_bit_rate,
	output logic                    o_link_up,
	output logic                    o_tx_dir
);
	localparam logic [3:0] FRAME_LAST = 4'h9;

	logic [3:0] bit_cnt_reg;
	logic       sent_reg;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_link_up <= 1'b0;
		else
			o_link_up <= i_cfg_valid && (3'(i_bit_rate) == MASTER_RATE);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_tx_dir    <= 1'b0;
			bit_cnt_reg <= 4'h0;
			sent_reg    <= 1'b0;
		end
		else if (o_tx_dir)
		begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			if (bit_cnt_reg == FRAME_LAST)
			begin
				o_tx_dir <= 1'b0;
				sent_reg <= 1'b1;
			end
		end
		else if (o_link_up && !sent_reg)
		begin
			o_tx_dir    <= 1'b1;
			bit_cnt_reg <= 4'h0;
		end
	end
endmodule
`default_nettype wire

/* test_node_address_and_status_outputs.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_node_address_and_status_outputs;
	logic               clk, rst, can, cdm, rerr, busy, refr, otmp, flt, vld, link;
	logic               lp, ln, en, rin, stp, sup, txd;
	logic [3:0]         sw, swh;
	logic [6:0]         nva, addr;
	logic [2:0]         nvr, pen, pval, sa, so, soe;
	logic [5:0]         din, dah, dact;
	logic [17:0]        dfn;
	nas_pkg::nas_rate_e rate;
	int                 err_count = 0;
	int                 checked = 0;

	nas_top #(.STARTUP_CYC(8)) dut (.i_clk_sys(clk), .i_rst(rst), .i_rot_sw(sw),
		.i_nv_addr(nva), .i_nv_rate(nvr), .i_canopen(can), .i_din(din),
		.i_din_act_high(dah), .i_din_func(dfn), .i_clkdir_mode(cdm), .i_rot_err(rerr),
		.i_busy(busy), .i_ref_reached(refr), .i_overtemp(otmp), .i_fault(flt),
		.i_out_prog_en(pen), .i_out_prog_val(pval), .o_node_address(addr),
		.o_bit_rate(rate), .o_sw_held(swh), .o_cfg_valid(vld), .o_din_active(dact),
		.o_lim_pos(lp), .o_lim_neg(ln), .o_enable(en), .o_ref_in(rin), .o_step_clk(stp),
		.o_startup(sup), .o_stat_active(sa), .o_stat_o(so), .o_stat_oe(soe));
	nas_master_model #(.MASTER_RATE(3'h2)) master (.i_clk_sys(clk), .i_rst(rst),
		.i_cfg_valid(vld), .i_bit_rate(rate), .o_link_up(link), .o_tx_dir(txd));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task complete_run;
		$display("err_count %0d checked %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task do_reset(input int n, input logic [3:0] s, input logic [6:0] a,
		input logic [2:0] r, input logic c);
		@(posedge clk);
		rst <= 1'b1;
		sw <= s;
		nva <= a;
		nvr <= r;
		can <= c;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task wait_run;
		int k;
		k = 0;
		while (sup !== 1'b0 && k < 40)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		if (sup !== 1'b0)
		begin
			err_count++;
			$display("Error startup end expected 0 seen 1");
			complete_run;
		end
	endtask

	task chk_cfg(input logic [3:0] s, input logic [6:0] a, input logic [2:0] r,
		input logic c);
		logic [6:0] ea;
		logic [2:0] er;
		ea = (s[2:0] == 3'h0) ? a : {3'h0, (s > 4'h8) ? s - 4'h8 : s};
		er = (s == 4'h0 && c) ? 3'h0 : ((r > 3'h5) ? 3'h0 : r);
		do_reset(2, s, a, r, c);
		`CHK("valid", 1'b1, vld)
		`CHK("address", ea, addr)
		`CHK("rate", er, 3'(rate))
		`CHK("switch", s, swh)
		@(posedge clk);
		sw <= ~s;
		nva <= ~a;
		nvr <= r + 3'h1;
		can <= ~c;
		settle;
		`CHK("held address", ea, addr)
		`CHK("held rate", er, 3'(rate))
		`CHK("held switch", s, swh)
	endtask

	task t_switch;
		for (int i = 0; i < 32; i++)
			chk_cfg(4'(i), 7'h5A, 3'h3, i[4]);
	endtask

	task t_rate;
		for (int i = 0; i < 8; i++)
		begin
			chk_cfg(4'h9, 7'h11, 3'(i), 1'b1);
			`CHK("link", (i == 2), link)
			`CHK("tx start", (i == 2), txd)
			repeat (8) @(posedge clk);
			#1;
			`CHK("tx frame", (i == 2), txd)
			repeat (2) @(posedge clk);
			#1;
			`CHK("tx stop", 1'b0, txd)
		end
	endtask

	task t_startup;
		do_reset(20, 4'h3, 7'h40, 3'h1, 1'b0);
		`CHK("startup", 1'b1, sup)
		settle;
		`CHK("out3 startup", 1'b1, sa[2])
		wait_run;
		settle;
		`CHK("out3 run", 1'b0, sa[2])
	endtask

	task st(input logic [4:0] c, input logic [2:0] pe, input logic [2:0] pv,
		input logic [2:0] e);
		@(posedge clk);
		{rerr, refr, busy, otmp, flt} <= c;
		pen <= pe;
		pval <= pv;
		settle;
		`CHK("status", e, sa)
		`CHK("drain enable", e, soe)
		`CHK("drain level", 3'h0, so)
	endtask

	task t_status;
		st(5'b00000, 3'h0, 3'h0, 3'b001);
		st(5'b00100, 3'h0, 3'h0, 3'b010);
		st(5'b01100, 3'h0, 3'h0, 3'b011);
		st(5'b11100, 3'h0, 3'h0, 3'b000);
		st(5'b00010, 3'h0, 3'h0, 3'b101);
		st(5'b00001, 3'h0, 3'h0, 3'b101);
		st(5'b00100, 3'b101, 3'b100, 3'b110);
		st(5'b00000, 3'h0, 3'h0, 3'b001);
	endtask

	task t_canopen;
		do_reset(2, 4'h1, 7'h22, 3'h4, 1'b1);
		wait_run;
		@(posedge clk);
		busy <= 1'b1;
		settle;
		`CHK("canopen busy", 2'h0, sa[1:0])
		@(posedge clk);
		busy <= 1'b0;
		settle;
		`CHK("canopen idle", 2'h0, sa[1:0])
	endtask

	task t_inputs;
		@(posedge clk);
		dah <= 6'b000111;
		din <= 6'b001010;
		dfn <= {3'h4, 3'h3, 3'h0, 3'h2, 3'h1, 3'h3};
		busy <= 1'b1;
		settle;
		`CHK("active", ~(6'b001010 ^ 6'b000111), dact)
		`CHK("funcs", 4'b1011, {lp, ln, en, rin})
		`CHK("limit code", 2'h0, sa[1:0])
		@(posedge clk);
		din <= 6'b111001;
		cdm <= 1'b1;
		dfn <= 18'h00003;
		busy <= 1'b0;
		settle;
		`CHK("step on", 2'b10, {stp, en})
		@(posedge clk);
		cdm <= 1'b0;
		settle;
		`CHK("step off", 2'b01, {stp, en})
	endtask

	initial
	begin
		rst = 1'b1;
		{sw, nva, nvr, can, cdm, rerr, busy, refr, otmp, flt} = '0;
		{din, dah, dfn, pen, pval} = '0;
		t_startup;
		t_status;
		t_inputs;
		t_canopen;
		t_switch;
		t_rate;
		complete_run;
	end
endmodule
`default_nettype wire
